/* File: engine_model.sv */
// Behavioural measurement engines answering start pulses
`timescale 1ns/1ps
module engine_model (
	// Clock
	input  wire       clock,
	// Engine handshake
	input  wire [3:0] start,
	input  wire [3:0] ext,
	input  wire [3:0] is_ext,
	output reg  [3:0] valid = 4'h0
);
	integer   i;
	reg [3:0] run = 4'h0;
	always @(posedge clock) begin
		for (i = 0; i < 4; i = i + 1) begin
			if (start[i]) begin
				valid[i] <= 1'h0;
				run[i] <= 1'h1;
			end else if (run[i] && (!is_ext[i] || ext[i])) begin
				valid[i] <= 1'h1;
				run[i] <= 1'h0;
			end
		end
	end
endmodule

/* File: measurement_trigger_sequencer.v */
// Measurement trigger sequencer with Avalon-MM register slave
//
// Behaviour
// - immediate trigger starts cycle under current mode
// - GET, star-TRG and immediate trigger identical
// - trigger with or without immediate keyword
// - abort ends cycle, ready for commands
// - one mode for all measurements, two parameters
// - rearm policy: continuous or one-shot
// - settle policy: fast or full
// - fast settle skips transient settling wait
// - operation complete needs all results, signals
// - external measurements armed by trigger, wait
// - one-shot disarms after each cycle
// - continuous rearms external measurement automatically
// - retry without timeout until valid or abort
// - result read holds off until available
// - trigger starts on engines; complete when all valid
// - frequency engines gate for programmed milliseconds
// - full settle, continuous on reset events
// - one-shot holds results until next trigger; abort also clears the hold
// - continuous restarts right after valid result
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "trig_seq_consts.vh"

module measurement_trigger_sequencer (
	// Clock and reset
	input  wire                    clock,
	input  wire                    nrst,
	// Avalon-MM slave
	input  wire [3:0]              address,
	input  wire                    read,
	input  wire                    write,
	input  wire [31:0]             writedata,
	input  wire [3:0]              byteenable,
	output reg  [31:0]             readdata,
	output reg                     waitrequest,
	// Measurement engines
	output reg  [`NUM_MEAS-1:0]    meas_start,
	input  wire [`NUM_MEAS-1:0]    meas_valid,
	input  wire [`NUM_MEAS-1:0]    meas_external,
	input  wire [`NUM_MEAS-1:0]    meas_ext_event,
	input  wire [`NUM_MEAS-1:0]    meas_is_freq,
	output reg  [`NUM_MEAS-1:0]    result_hold,
	// Generator status
	input  wire                    signals_in_spec,
	// Status
	output reg                     busy,
	output reg                     op_complete
);
	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_SETTLE = 3'h1;
	localparam [2:0] ST_ARM    = 3'h2;
	localparam [2:0] ST_GATE   = 3'h3;
	localparam [2:0] ST_WAIT   = 3'h4;
	localparam [2:0] ST_DONE   = 3'h5;

	reg [2:0]            state_r;
	reg                  rearm_policy_r;
	reg                  settle_full_r;
	reg                  mode_set_r;
	reg                  saved_rearm_r;
	reg                  saved_settle_r;
	reg [`NUM_MEAS-1:0]  enable_r;
	reg [`NUM_MEAS-1:0]  active_r;
	reg [`NUM_MEAS-1:0]  got_valid_r;
	reg [15:0]           audio_counter_gate_r;
	reg [15:0]           radio_counter_gate_r;
	reg [15:0]           settle_ms_r;
	reg [15:0]           ms_left_r;
	reg [1:0]            flush_r;
	reg                  complete_r;
	reg                  armed_r;
	reg                  pend_rd_r;
	reg [`NUM_MEAS-1:0]  valid_s1_r;
	reg [`NUM_MEAS-1:0]  valid_s2_r;
	reg [`NUM_MEAS-1:0]  ext_s1_r;
	reg [`NUM_MEAS-1:0]  ext_s2_r;
	reg                  spec_s1_r;
	reg                  spec_s2_r;

	wire       ms_pulse;
	// Write acts only at the edge that accepts it
	wire       wr_req = write & ~read;
	wire       wr     = wr_req & ~waitrequest;
	wire       wr_ctl = wr & (address == `REG_CTRL) & byteenable[0];
	wire       ctl_hi = wr & (address == `REG_CTRL) & byteenable[1];
	wire       trig_cmd;
	wire       abort_cmd;
	wire       default_cmd;
	wire       remote_cmd;
	wire [15:0] gate_ms;
	wire       all_valid;
	wire       opc_now;
	wire       remote_rearm;
	wire       remote_settle;
	wire [`NUM_MEAS-1:0] fresh_valid;

	// Three bus forms and bare trigger are one event
	assign trig_cmd = wr_ctl & (writedata[`CTRL_TRIG_IMM] |
		writedata[`CTRL_TRIG_BARE] | writedata[`CTRL_TRIG_GET] |
		writedata[`CTRL_TRIG_STAR]);
	assign abort_cmd   = wr_ctl & writedata[`CTRL_ABORT];
	assign default_cmd = (wr_ctl & (writedata[`CTRL_PRESET] |
		writedata[`CTRL_RESET_CMD] | writedata[`CTRL_GO_LOCAL]));
	assign remote_cmd  = ctl_hi & writedata[`CTRL_GO_REMOTE];
	assign remote_rearm  = mode_set_r ? saved_rearm_r : `REARM_CONTINUOUS;
	assign remote_settle = mode_set_r ? saved_settle_r : `SETTLE_FULL;

	// Longer of the audio and radio gates when any active engine is a frequency engine
	assign gate_ms = (|(active_r & meas_is_freq)) ?
		((audio_counter_gate_r > radio_counter_gate_r) ?
		audio_counter_gate_r : radio_counter_gate_r) : 16'h0000;

	// Complete only when every active engine holds a result
	// External engines count only with their event
	assign fresh_valid = valid_s2_r & (~meas_external | ext_s2_r);
	assign all_valid = ((got_valid_r | fresh_valid) & active_r) == active_r;
	assign opc_now   = complete_r & spec_s2_r;

	ms_tick u_ms_tick (
		.clock (clock),
		.nrst  (nrst),
		.clear (state_r == ST_IDLE),
		.tick  (ms_pulse)
	);

	// Synchronisers for engine and generator inputs
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			valid_s1_r <= {`NUM_MEAS{1'b0}};
			valid_s2_r <= {`NUM_MEAS{1'b0}};
			ext_s1_r   <= {`NUM_MEAS{1'b0}};
			ext_s2_r   <= {`NUM_MEAS{1'b0}};
			spec_s1_r  <= 1'b0;
			spec_s2_r  <= 1'b0;
		end else begin
			valid_s1_r <= meas_valid;
			valid_s2_r <= valid_s1_r;
			ext_s1_r   <= meas_ext_event;
			ext_s2_r   <= ext_s1_r;
			spec_s1_r  <= signals_in_spec;
			spec_s2_r  <= spec_s1_r;
		end
	end

	// Mode and configuration registers
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rearm_policy_r       <= `REARM_CONTINUOUS;
			settle_full_r        <= `SETTLE_FULL;
			mode_set_r           <= 1'b0;
			saved_rearm_r        <= `REARM_CONTINUOUS;
			saved_settle_r       <= `SETTLE_FULL;
			enable_r             <= `MEAS_ENABLE_RST;
			audio_counter_gate_r <= `GATE_RST;
			radio_counter_gate_r <= `GATE_RST;
			settle_ms_r          <= `SETTLE_RST;
		end else if (default_cmd) begin
			rearm_policy_r <= `REARM_CONTINUOUS;
			settle_full_r  <= `SETTLE_FULL;
			if (!writedata[`CTRL_GO_LOCAL]) begin
				mode_set_r     <= 1'b0;
				saved_rearm_r  <= `REARM_CONTINUOUS;
				saved_settle_r <= `SETTLE_FULL;
			end
		end else if (remote_cmd) begin
			// Last remote mode, or default if never set
			rearm_policy_r <= remote_rearm;
			settle_full_r  <= remote_settle;
		end else if (wr) begin
			case (address)
				`REG_MODE: begin
					if (byteenable[0]) begin
						// One setting shared by all engines
						rearm_policy_r <= writedata[`MODE_REARM_BIT];
						settle_full_r  <= writedata[`MODE_SETTLE_BIT];
						saved_rearm_r  <= writedata[`MODE_REARM_BIT];
						saved_settle_r <= writedata[`MODE_SETTLE_BIT];
						mode_set_r     <= 1'b1;
					end
				end
				`REG_ENABLE: begin
					if (byteenable[0])
						enable_r <= writedata[`NUM_MEAS-1:0];
				end
				`REG_GATE_AUDIO: begin
					if (byteenable[0])
						audio_counter_gate_r[7:0] <= writedata[7:0];
					if (byteenable[1])
						audio_counter_gate_r[15:8] <= writedata[15:8];
				end
				`REG_GATE_RADIO: begin
					if (byteenable[0])
						radio_counter_gate_r[7:0] <= writedata[7:0];
					if (byteenable[1])
						radio_counter_gate_r[15:8] <= writedata[15:8];
				end
				`REG_SETTLE: begin
					if (byteenable[0])
						settle_ms_r[7:0] <= writedata[7:0];
					if (byteenable[1])
						settle_ms_r[15:8] <= writedata[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	// Cycle sequencer
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r     <= ST_IDLE;
			active_r    <= {`NUM_MEAS{1'b0}};
			got_valid_r <= {`NUM_MEAS{1'b0}};
			ms_left_r   <= 16'h0000;
			flush_r     <= 2'h0;
			complete_r  <= 1'b0;
			armed_r     <= 1'b0;
			meas_start  <= {`NUM_MEAS{1'b0}};
			result_hold <= {`NUM_MEAS{1'b0}};
		end else begin
			meas_start <= {`NUM_MEAS{1'b0}};
			if (abort_cmd) begin
				state_r     <= ST_IDLE;
				armed_r     <= 1'b0;
				result_hold <= {`NUM_MEAS{1'b0}};
			end else if (trig_cmd | (remote_cmd & remote_rearm)) begin
				// Old results invalid; settle mode read at trigger
				active_r    <= enable_r;
				got_valid_r <= {`NUM_MEAS{1'b0}};
				complete_r  <= 1'b0;
				result_hold <= {`NUM_MEAS{1'b0}};
				armed_r     <= |(enable_r & meas_external);
				if (remote_cmd ? remote_settle : settle_full_r) begin
					state_r   <= ST_SETTLE;
					ms_left_r <= settle_ms_r;
				end else begin
					state_r <= ST_ARM;
				end
			end else begin
				case (state_r)
					ST_IDLE: begin
					end
					ST_SETTLE: begin
						if (ms_left_r == 16'h0000)
							state_r <= ST_ARM;
						else if (ms_pulse)
							ms_left_r <= ms_left_r - 16'h0001;
					end
					ST_ARM: begin
						meas_start <= active_r;
						ms_left_r  <= gate_ms;
						flush_r    <= 2'h3;
						state_r    <= ST_GATE;
					end
					ST_GATE: begin
						// Let stale valid flags drain the synchronisers
						if (flush_r != 2'h0)
							flush_r <= flush_r - 2'h1;
						if (ms_left_r != 16'h0000) begin
							if (ms_pulse)
								ms_left_r <= ms_left_r - 16'h0001;
						end else if (flush_r == 2'h0) begin
							state_r <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						// Armed engines need their external event
						got_valid_r <= got_valid_r | fresh_valid;
						// No timeout: waits until valid or abort
						if (all_valid)
							state_r <= ST_DONE;
					end
					ST_DONE: begin
						complete_r <= 1'b1;
						if (rearm_policy_r == `REARM_CONTINUOUS) begin
							// Immediate restart and rearm
							got_valid_r <= {`NUM_MEAS{1'b0}};
							state_r     <= ST_ARM;
						end else begin
							// Disarm and hold results
							armed_r     <= 1'b0;
							result_hold <= active_r;
							state_r     <= ST_IDLE;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Avalon slave: writes one cycle; status read held off
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			readdata    <= 32'h00000000;
			waitrequest <= 1'b1;
			pend_rd_r   <= 1'b0;
			busy        <= 1'b0;
			op_complete <= 1'b0;
		end else begin
			busy        <= (state_r != ST_IDLE);
			op_complete <= opc_now;
			waitrequest <= 1'b1;
			pend_rd_r   <= 1'b0;
			if (wr_req & waitrequest) begin
				waitrequest <= 1'b0;
			end else if (read & waitrequest & ~pend_rd_r) begin
				pend_rd_r <= 1'b1;
			end else if (read & pend_rd_r) begin
				pend_rd_r <= 1'b1;
				if (address != `REG_STATUS | opc_now |
						state_r == ST_IDLE) begin
					waitrequest <= 1'b0;
					pend_rd_r   <= 1'b0;
					case (address)
						`REG_MODE: readdata <= {29'h0, mode_set_r,
							settle_full_r, rearm_policy_r};
						`REG_STATUS: readdata <= {12'h000, active_r,
							got_valid_r, 1'b0, state_r, 3'h0, opc_now,
							spec_s2_r, armed_r, complete_r,
							state_r != ST_IDLE};
						`REG_ENABLE: readdata <= {28'h0, enable_r};
						`REG_GATE_AUDIO: readdata <= {16'h0000,
							audio_counter_gate_r};
						`REG_GATE_RADIO: readdata <= {16'h0000,
							radio_counter_gate_r};
						`REG_SETTLE: readdata <= {16'h0000, settle_ms_r};
						default: readdata <= 32'h00000000;
					endcase
				end
			end
		end
	end
endmodule

/* File: measurement_trigger_sequencer_tb.sv */
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps
`include "trig_seq_consts.vh"
module measurement_trigger_sequencer_tb;
	reg         clock = 1'h0;
	reg         nrst = 1'h0;
	reg  [3:0]  address = 4'h0;
	reg         read = 1'h0;
	reg         write = 1'h0;
	reg  [31:0] writedata = 32'h0;
	reg  [3:0]  ext = 4'h0;
	reg         in_spec = 1'h1;
	wire [31:0] readdata;
	wire        waitrequest;
	wire [3:0]  start;
	wire [3:0]  valid;
	wire [3:0]  hold;
	wire        busy;
	wire        op_complete;
	reg  [3:0]  seen_st = 4'h0;
	reg  [31:0] rdat;
	integer     n_fail = 0;
	integer     checks = 0;
	integer     n3 = 0;
	integer     cyc = 0;
	integer     k;
	integer     t0;

	always #12.5 clock = ~clock;
	always @(posedge clock) cyc = cyc + 1;
	always @(negedge clock) begin
		seen_st = seen_st | start;
		n3 = n3 + start[3];
	end

	measurement_trigger_sequencer dut (
		.clock(clock), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hF),
		.readdata(readdata), .waitrequest(waitrequest),
		.meas_start(start), .meas_valid(valid), .meas_external(4'h8),
		.meas_ext_event(ext), .meas_is_freq(4'h1), .result_hold(hold),
		.signals_in_spec(in_spec), .busy(busy), .op_complete(op_complete));
	engine_model eng (.clock(clock), .start(start), .ext(ext),
		.is_ext(4'h8), .valid(valid));

	task complete_run;
		begin
			if (n_fail == 0 && checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: %h not %h", $time, seen, exp);
			end
		end
	endtask

	task waited(input ok);
		if (!ok) begin
			n_fail = n_fail + 1;
			complete_run;
		end
	endtask

	task bus(input w, input [3:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clock);
			address <= a;
			writedata <= d;
			write <= w;
			read <= !w;
			n = 0;
			@(posedge clock);
			while (waitrequest !== 1'h0 && n < 2000) begin
				@(posedge clock);
				n = n + 1;
			end
			rdat = readdata;
			write <= 1'h0;
			read <= 1'h0;
			waited(n < 2000);
		end
	endtask

	task await_done;
		integer n;
		begin
			n = 0;
			repeat (4) @(posedge clock);
			while (op_complete !== 1'h1 && n < 100000) begin
				@(posedge clock);
				n = n + 1;
			end
			waited(n < 100000);
			repeat (2) @(posedge clock);
		end
	endtask

	initial begin
		repeat (4) @(posedge clock);
		nrst <= 1'h1;
		bus(0, `REG_MODE, 32'h0);
		chk(rdat, 32'h3);
		bus(0, `REG_ENABLE, 32'h0);
		chk(rdat, 32'hF);
		bus(0, `REG_SETTLE, 32'h0);
		chk(rdat, 32'h28);
		bus(0, 4'hF, 32'h0);
		chk(rdat, 32'h0);
		for (k = 4; k < 7; k = k + 1)
			bus(1, k[3:0], 32'h0);
		bus(1, `REG_MODE, 32'h0);
		for (k = 0; k < 4; k = k + 1) begin
			seen_st = 4'h0;
			bus(1, `REG_CTRL, 32'h1 << k);
			repeat (8) @(posedge clock);
			chk(seen_st, 4'hF);
			repeat (32) @(posedge clock);
			chk({busy, op_complete}, 2'h2);
			ext <= 4'h8;
			await_done;
			chk({busy, hold}, 5'h0F);
			ext <= 4'h0;
		end
		seen_st = 4'h0;
		ext <= 4'h8;
		repeat (20) @(posedge clock);
		chk({busy, seen_st}, 5'h00);
		ext <= 4'h0;
		bus(1, `REG_ENABLE, 32'h3);
		in_spec <= 1'h0;
		seen_st = 4'h0;
		bus(1, `REG_CTRL, 32'h1);
		repeat (40) @(posedge clock);
		chk(op_complete, 1'h0);
		in_spec <= 1'h1;
		await_done;
		chk(seen_st, 4'h3);
		bus(1, `REG_ENABLE, 32'hF);
		bus(1, `REG_CTRL, 32'h1);
		t0 = cyc;
		fork
			bus(0, `REG_STATUS, 32'h0);
			begin
				repeat (30) @(posedge clock);
				ext <= 4'h8;
			end
		join
		chk(cyc - t0 > 30, 1'h1);
		chk(rdat, 32'h000FF01A);
		ext <= 4'h0;
		bus(1, `REG_CTRL, 32'h1);
		repeat (20) @(posedge clock);
		bus(1, `REG_CTRL, 32'h10);
		repeat (4) @(posedge clock);
		chk(busy, 1'h0);
		bus(1, `REG_MODE, 32'h1);
		ext <= 4'h8;
		n3 = 0;
		bus(1, `REG_CTRL, 32'h1);
		repeat (200) @(posedge clock);
		chk(n3 > 2, 1'h1);
		bus(1, `REG_CTRL, 32'h10);
		ext <= 4'h0;
		for (k = 5; k < 8; k = k + 1) begin
			bus(1, `REG_MODE, 32'h0);
			bus(1, `REG_CTRL, 32'h1 << k);
			bus(0, `REG_MODE, 32'h0);
			chk(rdat[1:0], 2'h3);
		end
		bus(1, `REG_CTRL, 32'h100);
		bus(0, `REG_MODE, 32'h0);
		chk(rdat, 32'h4);
		chk(busy, 1'h0);
		bus(1, `REG_MODE, 32'h2);
		bus(1, `REG_SETTLE, 32'h1);
		bus(1, `REG_GATE_AUDIO, 32'h1);
		t0 = cyc;
		bus(1, `REG_CTRL, 32'h1);
		ext <= 4'h8;
		await_done;
		chk(cyc - t0 >= 80000, 1'h1);
		complete_run;
	end
endmodule

bind measurement_trigger_sequencer trig_seq_props props (
	.clock(clock), .nrst(nrst), .address(address), .read(read),
	.write(write), .writedata(writedata), .waitrequest(waitrequest),
	.meas_start(meas_start), .signals_in_spec(signals_in_spec),
	.result_hold(result_hold), .busy(busy), .op_complete(op_complete));

/* File: ms_tick.v */
// Divider giving a one-cycle enable pulse every millisecond
`timescale 1ns/1ps
`include "trig_seq_consts.vh"

module ms_tick (
	// Clock and reset
	input  wire clock,
	input  wire nrst,
	// Divider control and output
	input  wire clear,
	output reg  tick
);
	localparam [`MS_CYCLES_W-1:0] LAST = `MS_LAST;
	reg [`MS_CYCLES_W-1:0] cnt_r;

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= {`MS_CYCLES_W{1'b0}};
			tick  <= 1'b0;
		end else if (clear) begin
			cnt_r <= {`MS_CYCLES_W{1'b0}};
			tick  <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r <= {`MS_CYCLES_W{1'b0}};
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule

/* File: trig_seq_consts.vh */
// Offsets, fields, reset values and timing counts of the trigger sequencer
`ifndef TRIG_SEQ_CONSTS_VH
`define TRIG_SEQ_CONSTS_VH

`define NUM_MEAS            4
// Register word offsets (byte address = 4 * index)
`define REG_CTRL            4'h0
`define REG_MODE            4'h1
`define REG_STATUS          4'h2
`define REG_ENABLE          4'h3
`define REG_GATE_AUDIO      4'h4
`define REG_GATE_RADIO      4'h5
`define REG_SETTLE          4'h6
// Control register command bits (write one to act)
`define CTRL_TRIG_IMM       0
`define CTRL_TRIG_BARE      1
`define CTRL_TRIG_GET       2
`define CTRL_TRIG_STAR      3
`define CTRL_ABORT          4
`define CTRL_PRESET         5
`define CTRL_RESET_CMD      6
`define CTRL_GO_LOCAL       7
`define CTRL_GO_REMOTE      8
// Mode register fields
`define MODE_REARM_BIT      0
`define MODE_SETTLE_BIT     1
`define MODE_SET_BIT        2
`define REARM_CONTINUOUS    1'b1
`define REARM_ONE_SHOT      1'b0
`define SETTLE_FULL         1'b1
`define SETTLE_FAST         1'b0
// Status register fields
`define STAT_BUSY_BIT       0
`define STAT_COMPLETE_BIT   1
`define STAT_ARMED_BIT      2
`define STAT_SIGNALS_OK_BIT 3
`define STAT_OPC_BIT        4
`define STAT_STATE_LSB      8
`define STAT_VALID_LSB      12
`define STAT_RESULT_LSB     16
// Reset values
`define MEAS_ENABLE_RST     4'hF
`define GATE_RST            16'h000A
`define SETTLE_RST          16'h0028
// One millisecond in cycles at 40 MHz (25 ns)
`define CLOCK_HZ            40000000
`define MS_CYCLES           (`CLOCK_HZ / 1000)
`define MS_CYCLES_W         16
// Last divider count of a millisecond (40000 - 1)
`define MS_LAST             16'h9C3F

`endif

/* File: trig_seq_props.sv */
// Port assertions for the trigger sequencer
`timescale 1ns/1ps
`include "trig_seq_consts.vh"
module trig_seq_props (
	// Watched ports
	input wire                 clock,
	input wire                 nrst,
	input wire [3:0]           address,
	input wire                 read,
	input wire                 write,
	input wire [31:0]          writedata,
	input wire                 waitrequest,
	input wire [`NUM_MEAS-1:0] meas_start,
	input wire                 signals_in_spec,
	input wire [`NUM_MEAS-1:0] result_hold,
	input wire                 busy,
	input wire                 op_complete
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	wire ctl_w = write && !waitrequest && address == `REG_CTRL;
	AST_WR_ACK: assert property ($rose(write) |-> ##[1:2] !waitrequest)
		else $error("write not acknowledged");
	AST_ACK_ONE: assert property (!waitrequest |=> waitrequest)
		else $error("acknowledge longer than one cycle");
	AST_RD_ACK: assert property ($rose(read) && address != `REG_STATUS
		|-> ##[1:3] !waitrequest)
		else $error("read not answered");
	AST_START_BUSY: assert property (meas_start != 0 |-> busy)
		else $error("start while idle");
	AST_START_PULSE: assert property (meas_start != 0 |=> meas_start == 0)
		else $error("start longer than one cycle");
	AST_ABORT: assert property (ctl_w && writedata[`CTRL_ABORT]
		|-> ##[1:3] !busy)
		else $error("abort left sequencer busy");
	AST_OPC_SPEC: assert property ($rose(op_complete) |->
		$past(signals_in_spec, 2) || $past(signals_in_spec, 3))
		else $error("complete while signals out of spec");
	AST_HOLD_IDLE: assert property ($rose(result_hold != 0)
		|-> ##[0:1] !busy)
		else $error("results held while busy");
	cover property (ctl_w && writedata[`CTRL_ABORT]);
	cover property ($rose(op_complete));
	cover property ($rose(result_hold != 0));
endmodule
